// File: nfc_pkg.sv
// package for the parallel nor flash host controller: constants, types and operation codes
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// RL1: write only with strobe and select low
// RL2: address at last fall, data first rise
// RL3: read data valid with select, output enable low
// RL4: select high means device deselected, standby
// RL5: program single words into erased sectors only; the host does not check this, and the testbench overwrites a programmed word
// RL6: three unlock cycles then address and data
// RL7: word program ends within 20 us
// RL8: reads during program return status only
// RL9: device ignores commands while programming
// RL10: sector 2 KWord, block 32 KWord
// RL11: sector erase six cycles, last 30h
// RL12: block erase six cycles, last 50h
// RL13: erase address at fall, code at rise
// RL14: device ignores commands while erasing
// RL15: chip erase last cycle 10h to 5555h
// RL16: chip erase leaves all bits one
// RL17: chip erase reads give status only
// RL18: bit 7 poll, bit 6 toggle status
// RL19: reread twice on inconsistent status read
// RL20: array 16 bits, 128K to 512K words
// RL21: bit 7 inverted while programming, zero erasing
// RL22: bit 6 alternates while operation runs
// RL23: invalid cycle aborts the unlock sequence
// RL24: upper address bits from 11 pick sector
// RL25: unlock aa to 5555h, 55 to 2aaah
// RL26: no array data until completion reported
package nfc_pkg;
    //----------------------------------------------------------------------
    // geometry and codes
    //----------------------------------------------------------------------
    localparam int          NFC_ADDR_W      = 19;
    localparam int          NFC_SECTOR_LSB  = 11;
    localparam int          NFC_BLOCK_LSB   = 15;
    localparam logic [15:0] NFC_UNLOCK_A1   = 16'h5555;
    localparam logic [15:0] NFC_UNLOCK_A2   = 16'h2aaa;
    localparam logic [15:0] NFC_CODE_AA     = 16'h00aa;
    localparam logic [15:0] NFC_CODE_55     = 16'h0055;
    localparam logic [15:0] NFC_CODE_PROG   = 16'h00a0;
    localparam logic [15:0] NFC_CODE_ERASE  = 16'h0080;
    localparam logic [15:0] NFC_CODE_SECTOR = 16'h0030;
    localparam logic [15:0] NFC_CODE_BLOCK  = 16'h0050;
    localparam logic [15:0] NFC_CODE_CHIP   = 16'h0010;
    localparam int          NFC_POLL_BIT    = 7;
    localparam int          NFC_TOGGLE_BIT  = 6;
    localparam int          NFC_REREADS     = 2;
    //----------------------------------------------------------------------
    // timing
    //----------------------------------------------------------------------
    localparam int NFC_CLK_MHZ       = 50;
    localparam int NFC_PHASE_NS      = 100;
    localparam int NFC_PHASE_CYC     = (NFC_PHASE_NS * NFC_CLK_MHZ + 999) / 1000;
    localparam int NFC_PROG_MAX_US   = 20;
    localparam int NFC_PROG_MAX_CYC  = NFC_PROG_MAX_US * NFC_CLK_MHZ;
    localparam int NFC_ERASE_MAX_MS  = 100;
    localparam int NFC_ERASE_MAX_CYC = NFC_ERASE_MAX_MS * 1000 * NFC_CLK_MHZ;
    localparam int NFC_CNT_W         = 24;

    typedef enum logic [1:0] {
        NFC_OP_READ  = 2'b00,
        NFC_OP_PROG  = 2'b01,
        NFC_OP_ERASE = 2'b10
    } nfc_op_t;

    typedef enum logic [1:0] {
        NFC_ER_SECTOR = 2'b00,
        NFC_ER_BLOCK  = 2'b01,
        NFC_ER_CHIP   = 2'b10
    } nfc_erase_t;

    typedef struct packed {
        nfc_op_t               op;
        nfc_erase_t            kind;
        logic [NFC_ADDR_W-1:0] addr;
        logic [15:0]           data;
    } nfc_req_t;

    typedef struct packed {
        logic        done;
        logic        fail;
        logic [15:0] data;
    } nfc_rsp_t;
endpackage

// File: nfc_bus_cycle.sv
// one bus cycle on the flash pins, write or read, at fixed phase lengths
`timescale 1ns/1ps
module nfc_bus_cycle
    import nfc_pkg::*;
#(
    parameter int PHASE = NFC_PHASE_CYC
) (
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    input  wire logic                  start,
    input  wire logic                  is_write,
    input  wire logic [NFC_ADDR_W-1:0] addr,
    input  wire logic [15:0]           wdata,
    input  wire logic [15:0]           dq_in,
    output logic                       busy,
    output logic                       done,
    output logic [15:0]                rdata,
    output logic                       chip_sel_n,
    output logic                       out_en_n,
    output logic                       wr_strobe_n,
    output logic [NFC_ADDR_W-1:0]      addr_out,
    output logic [15:0]                dq_out,
    output logic                       dq_oe_n
);
    typedef enum logic [1:0] {
        NFC_BC_IDLE  = 2'b00,
        NFC_BC_SETUP = 2'b01,
        NFC_BC_PULSE = 2'b10,
        NFC_BC_HOLD  = 2'b11
    } nfc_bc_state_t;

    nfc_bc_state_t state;
    logic [7:0]    cnt;
    logic          wr;
    wire           phase_end = (cnt == 8'(PHASE - 1));

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state       <= NFC_BC_IDLE;
            cnt         <= 8'h00;
            wr          <= 1'b0;
            busy        <= 1'b0;
            done        <= 1'b0;
            rdata       <= 16'h0000;
            chip_sel_n  <= 1'b1;
            out_en_n    <= 1'b1;
            wr_strobe_n <= 1'b1;
            addr_out    <= '0;
            dq_out      <= 16'h0000;
            dq_oe_n     <= 1'b1;
        end else if (ce) begin
            done <= 1'b0;
            cnt  <= phase_end ? 8'h00 : cnt + 8'h01;
            case (state)
                NFC_BC_IDLE: begin
                    cnt <= 8'h00;
                    if (start) begin
                        // address settles while both strobes are high [RL2]
                        state      <= NFC_BC_SETUP;
                        busy       <= 1'b1;
                        wr         <= is_write;
                        addr_out   <= addr;
                        dq_out     <= wdata;
                        dq_oe_n    <= !is_write;
                        chip_sel_n <= 1'b0;
                    end
                end
                NFC_BC_SETUP: if (phase_end) begin
                    state <= NFC_BC_PULSE;
                    // select held low, strobe pulses low for a write [RL1]
                    if (wr) wr_strobe_n <= 1'b0;
                    else    out_en_n    <= 1'b0;
                end
                NFC_BC_PULSE: if (phase_end) begin
                    // strobe rises first, data still stable on the pins [RL2]
                    state       <= NFC_BC_HOLD;
                    wr_strobe_n <= 1'b1;
                    out_en_n    <= 1'b1;
                    if (!wr) rdata <= dq_in; // sampled with select and oe low [RL3]
                end
                NFC_BC_HOLD: if (phase_end) begin
                    // select released: device back in standby [RL4]
                    state      <= NFC_BC_IDLE;
                    chip_sel_n <= 1'b1;
                    dq_oe_n    <= 1'b1;
                    busy       <= 1'b0;
                    done       <= 1'b1;
                end
                default: state <= NFC_BC_IDLE;
            endcase
        end
    end
endmodule

// File: nfc_host.sv
// host controller sequencing program, erase and read operations on the flash pins
`timescale 1ns/1ps
module nfc_host
    import nfc_pkg::*;
#(
    parameter int PROG_MAX  = NFC_PROG_MAX_CYC,
    parameter int ERASE_MAX = NFC_ERASE_MAX_CYC
) (
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    input  wire logic                  req_valid,
    input  wire nfc_req_t              req,
    output logic                       req_ready,
    output nfc_rsp_t                   rsp,
    output logic                       chip_sel_n,
    output logic                       out_en_n,
    output logic                       wr_strobe_n,
    output logic [NFC_ADDR_W-1:0]      addr_out,
    output logic [15:0]                dq_out,
    output logic                       dq_oe_n,
    input  wire logic [15:0]           dq_in
);
    //----------------------------------------------------------------------
    // state
    //----------------------------------------------------------------------
    typedef enum logic [2:0] {
        NFC_ST_IDLE  = 3'b000,
        NFC_ST_CMD   = 3'b001,
        NFC_ST_WAIT  = 3'b010,
        NFC_ST_POLL  = 3'b011,
        NFC_ST_CHECK = 3'b100,
        NFC_ST_READ  = 3'b101,
        NFC_ST_DONE  = 3'b110
    } nfc_state_t;

    nfc_state_t           state;
    nfc_req_t             cur;
    logic [2:0]           step;
    logic [NFC_CNT_W-1:0] timer;
    logic [1:0]           rereads;
    logic [15:0]          last_rd;
    logic                 have_last;
    logic                 bc_start;
    logic                 bc_busy;
    logic                 bc_done;
    logic [15:0]          bc_rdata;

    //----------------------------------------------------------------------
    // command cycle selection
    //----------------------------------------------------------------------
    wire        is_prog    = (cur.op == NFC_OP_PROG);
    wire [2:0]  n_cycles   = is_prog ? 3'd4 : 3'd6;             // [RL6] [RL11] [RL12]
    wire        last_cycle = (step == n_cycles - 3'd1);
    wire [NFC_ADDR_W-1:0] sec_addr = {cur.addr[NFC_ADDR_W-1:NFC_SECTOR_LSB],
                                      {NFC_SECTOR_LSB{1'b0}}};  // [RL24] [RL10]
    wire [NFC_ADDR_W-1:0] blk_addr = {cur.addr[NFC_ADDR_W-1:NFC_BLOCK_LSB],
                                      {NFC_BLOCK_LSB{1'b0}}};   // [RL10]
    wire [NFC_ADDR_W-1:0] a1 = NFC_ADDR_W'(NFC_UNLOCK_A1);
    wire [NFC_ADDR_W-1:0] a2 = NFC_ADDR_W'(NFC_UNLOCK_A2);
    wire [15:0] erase_code = (cur.kind == NFC_ER_SECTOR) ? NFC_CODE_SECTOR :
                             (cur.kind == NFC_ER_BLOCK)  ? NFC_CODE_BLOCK  :
                                                           NFC_CODE_CHIP;   // [RL11] [RL12] [RL15]
    wire [NFC_ADDR_W-1:0] erase_addr = (cur.kind == NFC_ER_SECTOR) ? sec_addr :
                                       (cur.kind == NFC_ER_BLOCK)  ? blk_addr : a1; // [RL15]
    // unlock pair, opcode, second unlock pair before erase codes [RL25]
    wire        odd_step = (step == 3'd1) || (step == 3'd4);
    wire [NFC_ADDR_W-1:0] cyc_addr =
        last_cycle ? (is_prog ? cur.addr : erase_addr) :
        odd_step   ? a2 : a1;
    wire        op_step  = (step == 3'd2);
    wire [15:0] op_code  = is_prog ? NFC_CODE_PROG : NFC_CODE_ERASE;
    wire [15:0] cyc_data =
        last_cycle ? (is_prog ? cur.data : erase_code) :
        odd_step   ? NFC_CODE_55 :
        op_step    ? op_code : NFC_CODE_AA;

    //----------------------------------------------------------------------
    // completion status
    //----------------------------------------------------------------------
    // status bits of the poll read [RL18]
    wire poll_bit   = bc_rdata[NFC_POLL_BIT];
    wire toggle_now = bc_rdata[NFC_TOGGLE_BIT];
    // expected bit 7 at completion: true data for program, one for erase [RL21]
    wire want_bit   = is_prog ? cur.data[NFC_POLL_BIT] : 1'b1;
    // toggling stopped and polarity matches means finished [RL22]
    wire stable     = have_last && (toggle_now == last_rd[NFC_TOGGLE_BIT])
                      && (poll_bit == want_bit);
    wire check_ok   = (bc_rdata == last_rd) && (poll_bit == want_bit);
    // a word still different once settled was not erased before programming
    wire fin_ok     = is_prog ? (bc_rdata == cur.data) : (&bc_rdata);  // [RL16]

    //----------------------------------------------------------------------
    // request intake and timeout
    //----------------------------------------------------------------------
    // ready drops after every take, so a request held high is taken once
    wire take       = (state == NFC_ST_IDLE) && req_valid && req_ready;
    wire next_ready = (state == NFC_ST_IDLE) && !req_valid;
    // erase bound is a chosen figure, program bound the word program maximum
    wire [NFC_CNT_W-1:0] limit = is_prog ? NFC_CNT_W'(PROG_MAX) : NFC_CNT_W'(ERASE_MAX);
    wire timed_out  = (timer >= limit);
    wire timing     = (state == NFC_ST_WAIT) || (state == NFC_ST_POLL) || (state == NFC_ST_CHECK);
    // the timer saturates so a stuck device cannot wrap it back under the limit
    wire [NFC_CNT_W-1:0] next_timer = timed_out ? timer : timer + NFC_CNT_W'(1);

    //----------------------------------------------------------------------
    // bus cycle engine
    //----------------------------------------------------------------------
    // one engine runs writes and status reads, so both see the same pin timing
    wire bc_is_wr   = (state == NFC_ST_CMD);
    wire [NFC_ADDR_W-1:0] bc_addr = bc_is_wr ? cyc_addr : cur.addr;
    nfc_bus_cycle u_cycle (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .ce          (ce),
        .start       (bc_start),
        .is_write    (bc_is_wr),
        .addr        (bc_addr),
        .wdata       (cyc_data),
        .dq_in       (dq_in),
        .busy        (bc_busy),
        .done        (bc_done),
        .rdata       (bc_rdata),
        .chip_sel_n  (chip_sel_n),
        .out_en_n    (out_en_n),
        .wr_strobe_n (wr_strobe_n),
        .addr_out    (addr_out),
        .dq_out      (dq_out),
        .dq_oe_n     (dq_oe_n)
    );

    //----------------------------------------------------------------------
    // sequencer
    //----------------------------------------------------------------------
    // a fresh request is only taken in idle, so a command reaches a busy
    // device only after a timeout; the device would ignore it anyway [RL9] [RL14] [RL17]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state     <= NFC_ST_IDLE;
            cur       <= '0;
            step      <= 3'd0;
            timer     <= '0;
            rereads   <= 2'd0;
            last_rd   <= 16'h0000;
            have_last <= 1'b0;
            bc_start  <= 1'b0;
            req_ready <= 1'b0;
            rsp       <= '0;
        end else if (ce) begin
            bc_start  <= 1'b0;
            rsp.done  <= 1'b0;
            req_ready <= next_ready;
            if (timing)
                timer <= next_timer;
            case (state)
                NFC_ST_IDLE: if (take) begin
                    // caller is trusted to program only erased words [RL5]
                    cur       <= req;
                    step      <= 3'd0;
                    timer     <= '0;
                    have_last <= 1'b0;
                    rereads   <= 2'd0;
                    req_ready <= 1'b0;
                    bc_start  <= 1'b1;
                    state     <= (req.op == NFC_OP_READ) ? NFC_ST_READ : NFC_ST_CMD;
                end
                NFC_ST_CMD: if (bc_done) begin
                    // cycles are issued back to back with no foreign cycle
                    // between them, so the sequence never aborts [RL23]
                    step     <= step + 3'd1;
                    bc_start <= 1'b1;
                    if (last_cycle) begin
                        bc_start <= 1'b1;
                        state    <= NFC_ST_POLL; // status valid after last rise [RL18]
                    end
                end
                NFC_ST_POLL: if (bc_done) begin
                    // only status is read until completion is seen [RL8] [RL26]
                    last_rd   <= bc_rdata;
                    have_last <= 1'b1;
                    bc_start  <= 1'b1;
                    if (stable) begin
                        rereads <= 2'd0;
                        state   <= NFC_ST_CHECK;
                    end else if (timed_out) begin
                        state    <= NFC_ST_DONE;
                        rsp.fail <= 1'b1;     // program overran 20 us bound, or erase its own bound [RL7]
                        bc_start <= 1'b0;
                    end
                end
                NFC_ST_CHECK: if (bc_done) begin
                    // two confirming rereads before completion [RL19]
                    // a differing reread means the stable read was a race
                    if (!check_ok) begin
                        bc_start <= 1'b1;
                        state    <= NFC_ST_POLL;
                    end else if (rereads == 2'(NFC_REREADS - 1)) begin
                        state    <= NFC_ST_DONE;
                        rsp.fail <= !fin_ok;
                        rsp.data <= bc_rdata;
                    end else begin
                        rereads  <= rereads + 2'd1;
                        bc_start <= 1'b1;
                    end
                end
                NFC_ST_READ: if (bc_done) begin
                    rsp.data <= bc_rdata;
                    rsp.fail <= 1'b0;
                    state    <= NFC_ST_DONE;
                end
                // wait for the engine to go idle so the next take starts clean
                NFC_ST_DONE: if (!bc_busy) begin
                    rsp.done <= 1'b1;
                    state    <= NFC_ST_IDLE;
                end
                NFC_ST_WAIT: state <= NFC_ST_POLL;
                default: state <= NFC_ST_IDLE;
            endcase
            // fail stands until the next request is taken; data stands until a later read or check overwrites it
            if (take) rsp.fail <= 1'b0;
        end
    end
endmodule

// File: nfc_host_checker.sv
// concurrent checks on the flash pins of the host controller
`timescale 1ns/1ps
module nfc_host_checker
    import nfc_pkg::*;
(
    input wire logic                  core_clk,
    input wire logic                  rstn,
    input wire logic                  ce,
    input wire logic                  chip_sel_n,
    input wire logic                  out_en_n,
    input wire logic                  wr_strobe_n,
    input wire logic [NFC_ADDR_W-1:0] addr_out,
    input wire logic [15:0]           dq_out,
    input wire logic                  dq_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_wr_fall;
        $fell(wr_strobe_n);
    endsequence
    sequence s_wr_rise;
        $rose(wr_strobe_n);
    endsequence
    a_write_needs_sel: assert property (!wr_strobe_n |-> !chip_sel_n && out_en_n)
        else $error("write strobe without select");
    a_data_at_rise: assert property (s_wr_rise |-> !dq_oe_n && $stable(dq_out))
        else $error("write data not held to strobe rise");
    a_addr_at_fall: assert property (s_wr_fall |-> !chip_sel_n && $stable(addr_out))
        else $error("address moved at strobe fall");
    a_strobe_width: assert property (disable iff (!rstn || !ce) s_wr_fall |->
        !wr_strobe_n[*5] ##1 wr_strobe_n) else $error("write strobe width wrong");
    a_no_drive_read: assert property (!out_en_n |-> dq_oe_n && !chip_sel_n)
        else $error("host drives data during read");
    a_deselect_idle: assert property (chip_sel_n |-> wr_strobe_n && out_en_n)
        else $error("strobe active while deselected");
    a_unlock_aa: assert property (s_wr_fall ##0 (dq_out == NFC_CODE_AA)
        |-> addr_out == NFC_ADDR_W'(NFC_UNLOCK_A1)) else $error("first unlock address wrong");
    a_unlock_55: assert property (s_wr_fall ##0 (dq_out == NFC_CODE_55)
        |-> addr_out == NFC_ADDR_W'(NFC_UNLOCK_A2)) else $error("second unlock address wrong");
endmodule

bind nfc_host nfc_host_checker nfc_host_checker_i (.core_clk(core_clk), .rstn(rstn), .ce(ce),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
    .addr_out(addr_out), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

// File: nfc_flash_model.sv
// behavioural nor flash: write guard decoding, program, erase and status reads
`timescale 1ns/1ps
module nfc_flash_model
    import nfc_pkg::*;
#(
    parameter int PROG_NS  = 2000,
    parameter int ERASE_NS = 10000
) (
    input  wire logic                  chip_sel_n,
    input  wire logic                  out_en_n,
    input  wire logic                  wr_strobe_n,
    input  wire logic [NFC_ADDR_W-1:0] addr,
    input  wire logic [15:0]           dq_w,
    output logic [15:0]                dq_r
);
    logic [15:0]           mem [int];
    logic [NFC_ADDR_W-1:0] la = '0;
    logic [15:0]           last = '0;
    logic [15:0]           pdat = '0;
    logic                  busy = 1'b0;
    logic                  erasing = 1'b0;
    logic                  tog = 1'b0;
    int                    step = 0;
    function automatic logic [15:0] rd(input int a);
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction
    task automatic wipe(input int lsb);
        int base;
        base = (int'(la) >> lsb) << lsb;
        for (int k = base; k < base + (1 << lsb); k++) if (mem.exists(k)) mem.delete(k);
    endtask
    task automatic start(input int ns, input logic er);
        busy = 1'b1;
        erasing = er;
        busy <= #(ns) 1'b0;
    endtask
    task automatic cmd(input logic [15:0] d);
        logic g5;
        logic g2;
        g5 = (la == NFC_ADDR_W'(NFC_UNLOCK_A1));
        g2 = (la == NFC_ADDR_W'(NFC_UNLOCK_A2));
        // any unexpected cycle drops back to step 0, i.e. read mode
        case (step)
            0, 3: step = (g5 && d == NFC_CODE_AA) ? step + 1 : 0;
            1, 4: step = (g2 && d == NFC_CODE_55) ? step + 1 : 0;
            2: step = !g5 ? 0 : d == NFC_CODE_PROG ? 6 : d == NFC_CODE_ERASE ? 3 : 0;
            5: begin
                step = 0;
                if (d == NFC_CODE_SECTOR) wipe(NFC_SECTOR_LSB);
                else if (d == NFC_CODE_BLOCK) wipe(NFC_BLOCK_LSB);
                else if (d == NFC_CODE_CHIP && g5) mem.delete();
                else step = 7;
                if (step == 0) start(ERASE_NS, 1'b1);
                step = 0;
            end
            6: begin
                pdat = d;
                mem[int'(la)] = rd(int'(la)) & d; // programming only clears bits
                start(PROG_NS, 1'b0);
                step = 0;
            end
            default: step = 0;
        endcase
    endtask
    always @(negedge wr_strobe_n or negedge chip_sel_n)
        if (!wr_strobe_n && !chip_sel_n) la = addr;
    always @(posedge wr_strobe_n or posedge chip_sel_n)
        if ((wr_strobe_n ^ chip_sel_n) && out_en_n && !busy) cmd(dq_w);
    always @(negedge out_en_n) begin
        if (!chip_sel_n && busy) tog = ~tog;
        if (!chip_sel_n) last = busy ? {~pdat[15:8], ~erasing & ~pdat[7], tog, ~pdat[5:0]}
                                     : rd(int'(addr));
    end
    // released bus shows the inverse so a stale sample cannot pass
    assign dq_r = (!chip_sel_n && !out_en_n) ? last : ~last;
endmodule

// File: tb.sv
// testbench: host controller driving the behavioural flash model
`timescale 1ns/1ps
module tb;
    import nfc_pkg::*;
    logic                  core_clk = 1'b0, rstn = 1'b0, ce = 1'b1, req_valid = 1'b0;
    nfc_req_t              req = '0;
    nfc_rsp_t              rsp;
    logic                  req_ready, chip_sel_n, out_en_n, wr_strobe_n, dq_oe_n;
    logic [NFC_ADDR_W-1:0] addr_out;
    logic [15:0]           dq_out, dq_in, dq_flash;
    int                    n_fail = 0, comparisons = 0, n_wr = 0;
    always #10 core_clk = ~core_clk;
    assign dq_in = dq_oe_n ? dq_flash : dq_out;
    always @(posedge wr_strobe_n) if (!chip_sel_n) n_wr++;
    nfc_host #(.PROG_MAX(200), .ERASE_MAX(2000)) nfc_host_i (.core_clk(core_clk), .rstn(rstn),
        .ce(ce), .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
        .addr_out(addr_out), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
    nfc_flash_model nfc_flash_model_i (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .wr_strobe_n(wr_strobe_n), .addr(addr_out), .dq_w(dq_out), .dq_r(dq_flash));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one request, raised once ready is seen and held one cycle, then wait for done under a bound
    task automatic run(input nfc_op_t op, input nfc_erase_t kind,
                       input logic [NFC_ADDR_W-1:0] a, input logic [15:0] d);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 100) begin @(posedge core_clk); #1; k++; end
        n_wr = 0;
        req = '{op: op, kind: kind, addr: a, data: d};
        req_valid = 1'b1;
        @(posedge core_clk);
        #1 req_valid = 1'b0;
        k = 0;
        while (rsp.done !== 1'b1 && k < 6000) begin @(posedge core_clk); #1; k++; end
        check("done", rsp.done, 1'b1);
    endtask
    task automatic rd_chk(input logic [NFC_ADDR_W-1:0] a, input logic [15:0] exp);
        run(NFC_OP_READ, NFC_ER_SECTOR, a, 16'h0000);
        check("read data", rsp.data, exp);
    endtask
    task automatic t_program();
        rd_chk(19'h01234, 16'hffff);
        // the overwrite below breaks this on purpose to force the timeout
        run(NFC_OP_PROG, NFC_ER_SECTOR, 19'h01234, 16'h5a3c);
        check("prog cycles", n_wr, 4);
        check("prog fail", rsp.fail, 1'b0);
        rd_chk(19'h01234, 16'h5a3c);
        run(NFC_OP_PROG, NFC_ER_SECTOR, 19'h01234, 16'h00ff);
        check("overwrite fail", rsp.fail, 1'b1);
        rd_chk(19'h01234, 16'h003c);
        run(NFC_OP_PROG, NFC_ER_SECTOR, 19'h01a00, 16'h1357);
        run(NFC_OP_PROG, NFC_ER_SECTOR, 19'h09000, 16'h2468);
        run(NFC_OP_PROG, NFC_ER_SECTOR, 19'h71234, 16'h0f0f);
    endtask
    task automatic t_sector();
        run(NFC_OP_ERASE, NFC_ER_SECTOR, 19'h017ff, 16'h0000);
        check("sector cycles", n_wr, 6);
        check("sector fail", rsp.fail, 1'b0);
        rd_chk(19'h01234, 16'hffff);
        rd_chk(19'h01a00, 16'h1357);
    endtask
    task automatic t_block();
        run(NFC_OP_ERASE, NFC_ER_BLOCK, 19'h07800, 16'h0000);
        check("block cycles", n_wr, 6);
        rd_chk(19'h01a00, 16'hffff);
        rd_chk(19'h09000, 16'h2468);
    endtask
    task automatic t_chip();
        run(NFC_OP_ERASE, NFC_ER_CHIP, 19'h00000, 16'h0000);
        check("chip cycles", n_wr, 6);
        check("chip fail", rsp.fail, 1'b0);
        rd_chk(19'h09000, 16'hffff);
        rd_chk(19'h71234, 16'hffff);
    endtask
    // clock enable low in mid read: the four control pins must hold their levels
    task automatic t_freeze();
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 100) begin @(posedge core_clk); #1; k++; end
        req = '{op: NFC_OP_READ, kind: NFC_ER_SECTOR, addr: 19'h09000, data: 16'h0000};
        req_valid = 1'b1;
        @(posedge core_clk);
        #1 req_valid = 1'b0;
        repeat (7) @(posedge core_clk);
        #1 ce = 1'b0;
        repeat (20) @(posedge core_clk);
        #1 check("frozen pins", {chip_sel_n, out_en_n, wr_strobe_n, dq_oe_n}, 4'h3);
        ce = 1'b1;
        k = 0;
        while (rsp.done !== 1'b1 && k < 100) begin @(posedge core_clk); #1; k++; end
        check("frozen done", rsp.done, 1'b1);
        check("frozen data", rsp.data, 16'h2468);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        check("reset strobes", {chip_sel_n, out_en_n, wr_strobe_n, dq_oe_n}, 4'hf);
        check("reset ready", req_ready, 1'b0);
        rstn = 1'b1;
        t_program();
        t_freeze();
        t_sector();
        t_block();
        t_chip();
        summarize();
    end
    // the whole sequence needs well under 20k cycles; the bound is 50k
    initial begin
        #1000000;
        n_fail++;
        summarize();
    end
endmodule
